// [verilog/acp_pkg.sv]
// constants for the sampling converter output pipeline
// assumes a single 200 MHz system clock and a synchronous active-low reset
//
// Functional notes
// RULE1 - start conversion on every rising conversion clock edge (the code ignores edges during a running conversion)
// RULE2 - running conversion ignores abort or restart attempts
// RULE3 - output word refreshed about 70ns after start
// RULE4 - two-stage pipeline adds two conversion clock periods
// RULE5 - host latches on third rising edge after sample
// RULE6 - only rising edges time anything; any duty cycle
// RULE7 - result is two's complement; invert sign for offset
// RULE8 - flag high at either full-scale code
// RULE9 - flag travels with its word through pipeline
package acp_pkg;
  localparam int ACP_DATA_W = 12;
  localparam int ACP_CONV_NS = 70;
  localparam int ACP_CLK_PERIOD_NS = 5;
  // longest time rounds down, never below one cycle
  localparam int ACP_CONV_CYC_RAW = ACP_CONV_NS / ACP_CLK_PERIOD_NS;
  localparam int ACP_CONV_CYC = (ACP_CONV_CYC_RAW < 1) ? 1 : ACP_CONV_CYC_RAW;
  localparam int ACP_CNT_W = 8;
  localparam int ACP_PIPE_STAGES = 2;
  localparam logic [ACP_DATA_W-1:0] ACP_CODE_NEG_FS = 12'h800;
  localparam logic [ACP_DATA_W-1:0] ACP_CODE_POS_FS = 12'h7ff;
  localparam logic [ACP_DATA_W-1:0] ACP_CODE_RESET = 12'h000;
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_CONV = 2'b01,
    ACP_DONE = 2'b11
  } acp_state_t;
endpackage : acp_pkg

// [verilog/acp_converter.sv]
// conversion timing, result pipeline and two-entry output buffer
// assumes the conversion clock and sample are synchronous inputs on CLK_SYS_IN
`timescale 1ns/1ps
module acp_converter #(
  parameter int DATA_W = acp_pkg::ACP_DATA_W,
  parameter int CONV_CYC = acp_pkg::ACP_CONV_CYC
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // conversion clock and analog sample (already quantised)
  input wire logic CONV_CLK_IN,
  input wire logic [DATA_W-1:0] SAMPLE_IN,
  // parallel output toward host
  output logic [DATA_W-1:0] RESULT_OUT,
  output logic OUT_OF_RANGE_FLAG_OUT,
  output logic RESULT_VALID_OUT,
  input wire logic RESULT_READY_IN,
  // conversion busy
  output logic CONV_BUSY_OUT
);
  import acp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // the cycle counter is eight bits wide and the full-scale codes are twelve bits
  initial begin
    if (DATA_W != ACP_DATA_W) begin
      $error("acp_converter: DATA_W must match the full-scale code width");
    end
    if (CONV_CYC < 1) begin
      $error("acp_converter: CONV_CYC must be at least one cycle");
    end
    if (CONV_CYC > 255) begin
      $error("acp_converter: CONV_CYC does not fit the cycle counter");
    end
  end

  // either full-scale code marks the input as out of range
  function automatic logic full_scale(input logic [DATA_W-1:0] code);
    full_scale = (code == ACP_CODE_NEG_FS) || (code == ACP_CODE_POS_FS);
  endfunction : full_scale

  ////////////////////////////////////////////////////////////////////////////
  // rising edge detect on the conversion clock; falling edges are ignored
  // the reset value matches the idle-low level so no false edge follows reset
  logic conv_clk_q;
  wire conv_rise = CONV_CLK_IN & ~conv_clk_q; // RULE6

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      conv_clk_q <= 1'b0;
    end else begin
      conv_clk_q <= CONV_CLK_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  // the sample is held for the whole conversion, whatever the clock does
  acp_state_t state_q;
  acp_state_t state_d;
  logic [ACP_CNT_W-1:0] cnt_q;
  logic [ACP_CNT_W-1:0] cnt_d;
  logic [DATA_W-1:0] hold_q;
  logic [DATA_W-1:0] hold_d;

  wire in_conv = (state_q == ACP_CONV);
  wire conv_last = (cnt_q == ACP_CNT_W'(CONV_CYC - 1));
  wire conv_end = in_conv && conv_last;
  // an edge during a running conversion does not restart it
  wire start = conv_rise && !in_conv; // RULE1 RULE2

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    case (state_q)
      ACP_IDLE, ACP_DONE: begin
        state_d = ACP_IDLE;
        if (start) begin
          state_d = ACP_CONV; // RULE1
          cnt_d = '0;
          hold_d = SAMPLE_IN;
        end
      end
      ACP_CONV: begin
        cnt_d = cnt_q + 1'b1; // RULE2
        if (conv_end) begin
          state_d = ACP_DONE; // RULE3
        end
      end
      default: begin
        state_d = ACP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      state_q <= ACP_IDLE;
      cnt_q <= '0;
      hold_q <= ACP_CODE_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-stage pipeline advanced by accepted starts only, flag alongside
  // a rise ignored during a conversion must not shift older words either
  logic [DATA_W-1:0] done_word_q;
  logic done_flag_q;
  logic done_vld_q;
  logic [DATA_W-1:0] pipe_word_q [ACP_PIPE_STAGES];
  logic pipe_flag_q [ACP_PIPE_STAGES];
  logic [ACP_PIPE_STAGES-1:0] pipe_vld_q;

  wire fresh = (state_q == ACP_DONE);
  wire advance = start; // RULE2 RULE4
  wire fresh_flag = full_scale(hold_q); // RULE8
  // a word ending in the very cycle of the next start skips the result stage
  wire [DATA_W-1:0] stage_in_word = fresh ? hold_q : done_word_q;
  wire stage_in_flag = fresh ? fresh_flag : done_flag_q;
  wire stage_in_vld = fresh | done_vld_q;
  wire [DATA_W-1:0] tail_word = pipe_word_q[ACP_PIPE_STAGES-1];
  wire tail_flag = pipe_flag_q[ACP_PIPE_STAGES-1];
  wire tail_vld = pipe_vld_q[ACP_PIPE_STAGES-1];

  // result stage: the word of the conversion that has just ended
  // a word left here is shifted on by the start that begins the next conversion, so it is never overwritten
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      done_word_q <= ACP_CODE_RESET;
      done_flag_q <= 1'b0;
      done_vld_q <= 1'b0;
    end else if (advance) begin
      done_vld_q <= 1'b0;
    end else if (fresh) begin
      done_word_q <= hold_q; // RULE3 RULE7
      done_flag_q <= fresh_flag; // RULE8
      done_vld_q <= 1'b1;
    end
  end

  // stage shift on an accepted start
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      pipe_vld_q <= '0;
      for (int i = 0; i < ACP_PIPE_STAGES; i++) begin
        pipe_word_q[i] <= ACP_CODE_RESET;
        pipe_flag_q[i] <= 1'b0;
      end
    end else if (advance) begin
      pipe_word_q[0] <= stage_in_word; // RULE4
      pipe_flag_q[0] <= stage_in_flag; // RULE9
      pipe_vld_q[0] <= stage_in_vld;
      for (int i = 1; i < ACP_PIPE_STAGES; i++) begin
        pipe_word_q[i] <= pipe_word_q[i-1]; // RULE4
        pipe_flag_q[i] <= pipe_flag_q[i-1]; // RULE9
        pipe_vld_q[i] <= pipe_vld_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer; a stall by the host of up to two words loses no word
  // limitation: if the host stalls more than two words, later words are dropped
  logic [DATA_W:0] buf_q [2];
  logic [1:0] cnt_buf_q;

  wire buf_empty = (cnt_buf_q == 2'd0);
  wire buf_full = (cnt_buf_q == 2'd2);
  // a full buffer refuses the push even when a pop frees a slot this cycle
  wire push = advance && tail_vld && !buf_full;
  wire pop = !buf_empty && RESULT_READY_IN;
  wire [DATA_W:0] push_val = {tail_flag, tail_word};
  // the new word goes to the head slot when the head is free after this edge
  wire push_to_head = pop ? (cnt_buf_q == 2'd1) : buf_empty;
  wire [1:0] cnt_buf_d = cnt_buf_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      cnt_buf_q <= 2'd0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (pop) begin
        buf_q[0] <= buf_q[1];
      end
      if (push && push_to_head) begin
        buf_q[0] <= push_val;
      end else if (push) begin
        buf_q[1] <= push_val;
      end
      cnt_buf_q <= cnt_buf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs, one cycle behind the buffer head
  // valid therefore lags a pop by one cycle; the host paces its ready
  wire [DATA_W-1:0] head_word = buf_q[0][DATA_W-1:0];
  wire head_flag = buf_q[0][DATA_W];
  // busy comes from the next state so it rises one cycle after the start
  wire busy_next = (state_d == ACP_CONV);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      RESULT_OUT <= ACP_CODE_RESET;
      OUT_OF_RANGE_FLAG_OUT <= 1'b0;
      RESULT_VALID_OUT <= 1'b0;
      CONV_BUSY_OUT <= 1'b0;
    end else begin
      RESULT_OUT <= head_word;
      OUT_OF_RANGE_FLAG_OUT <= head_flag; // RULE9
      RESULT_VALID_OUT <= !buf_empty;
      CONV_BUSY_OUT <= busy_next;
    end
  end
endmodule : acp_converter

// [test/acp_converter_monitor.sv]
// checker on the converter ports, assuming the default 14-cycle conversion
`timescale 1ns/1ps
module acp_converter_monitor (
  input wire logic CLK_SYS_IN, RESETN_IN, CONV_CLK_IN, OUT_OF_RANGE_FLAG_OUT,
  input wire logic RESULT_VALID_OUT, RESULT_READY_IN, CONV_BUSY_OUT,
  input wire logic [11:0] RESULT_OUT
);
  wire b = CONV_BUSY_OUT, c = CONV_CLK_IN, v = RESULT_VALID_OUT, r = RESULT_READY_IN;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  a_flag_match: assert property (v |-> OUT_OF_RANGE_FLAG_OUT == (RESULT_OUT inside {12'h800, 12'h7ff}))
    else $error("flag");
  a_busy_start: assert property ($rose(c) && !b |=> b) else $error("start");
  a_busy_length: assert property ($rose(b) |-> b [*8] ##1 b [*6] ##1 !b) else $error("length");
  a_no_restart: assert property ($fell(b) |-> $past(b, 14) && !$past(b, 15)) else $error("restart");
  a_rise_only: assert property ($rose(b) |-> $past(c) && !$past(c, 2)) else $error("edge");
  a_push_timing: assert property ($rose(v) |-> $past(c, 2) && !$past(c, 3)) else $error("push");
  a_head_hold: assert property (v && !r && !$past(r) |=> v && $stable(RESULT_OUT)) else $error("hold");
  a_reset_quiet: assert property ($rose(RESETN_IN) |-> !v && !b) else $error("reset");
endmodule : acp_converter_monitor

// [test/acp_host_model.sv]
// host capture model: one word per valid unless stalled; valid lags each pop by a cycle
`timescale 1ns/1ps
module acp_host_model (
  input wire logic CLK_SYS_IN, RESULT_VALID_OUT, OUT_OF_RANGE_FLAG_OUT, stall_in,
  input wire logic [11:0] RESULT_OUT,
  output logic RESULT_READY_IN = 1'b0
);
  logic [12:0] got_q[$];
  int gap = 0;
  always @(posedge CLK_SYS_IN) begin
    RESULT_READY_IN <= 1'b0;
    if (gap > 0) gap <= gap - 1;
    else if (RESULT_VALID_OUT && !stall_in) begin
      got_q.push_back({OUT_OF_RANGE_FLAG_OUT, RESULT_OUT});
      RESULT_READY_IN <= 1'b1;
      gap <= 2;
    end
  end
endmodule : acp_host_model

// [test/acp_converter_tb_top.sv]
// bench streaming samples to the host model, assuming a 14-cycle conversion
`timescale 1ns/1ps
module acp_converter_tb_top;
  logic CLK_SYS_IN = 1'b0, RESETN_IN = 1'b0, CONV_CLK_IN = 1'b0, stall_in = 1'b0;
  logic RESULT_READY_IN, OUT_OF_RANGE_FLAG_OUT, RESULT_VALID_OUT, CONV_BUSY_OUT;
  logic [11:0] SAMPLE_IN = 12'h000, RESULT_OUT;
  logic [11:0] t[5] = '{12'h800, 12'h7ff, 12'h123, 12'hfff, 12'h801};
  int errors = 0, n_tests = 0;
  initial forever #2.5 CLK_SYS_IN = ~CLK_SYS_IN;
  acp_converter dut (.*);
  acp_host_model host (.*);
  task give_verdict;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task check(input logic [12:0] e, s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("unexpected word: expected %h seen %h", e, s);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge CLK_SYS_IN);
  endtask : tick
  // a second rise lands mid-conversion; st stalls the host so the buffer overflows
  task stream(input int hi, input logic st);
    RESETN_IN <= 1'b0;
    stall_in <= st;
    tick(12);
    RESETN_IN <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      SAMPLE_IN <= t[k % 5];
      CONV_CLK_IN <= 1'b1;
      tick(1);
      CONV_CLK_IN <= 1'b0;
      tick(1);
      CONV_CLK_IN <= 1'b1;
      tick(hi);
      CONV_CLK_IN <= 1'b0;
      tick(18 - hi);
    end
    tick(20);
    stall_in <= 1'b0;
    tick(30);
    check(st ? 13'd2 : 13'd5, 13'(host.got_q.size()));
    for (int i = 0; i < host.got_q.size() && i < 5; i++)
      check({t[i] inside {12'h800, 12'h7ff}, t[i]}, host.got_q[i]);
    host.got_q.delete();
  endtask : stream
  initial begin
    stream(2, 1'b0);
    stream(12, 1'b0);
    stream(2, 1'b1);
    give_verdict();
  end
endmodule : acp_converter_tb_top
bind acp_converter acp_converter_monitor mon (.*);
